//--- logic/torque_detect_map.vh
// register map, field limits and timing constants of the torque detector
// assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus
`ifndef TORQUE_DETECT_MAP_VH
`define TORQUE_DETECT_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_SELECT_ONE 16'h04A1
`define IDX_LEVEL_ONE 16'h04A2
`define IDX_TIME_ONE 16'h04A3
`define IDX_SELECT_TWO 16'h04A4
`define IDX_LEVEL_TWO 16'h04A5
`define IDX_TIME_TWO 16'h04A6
`define IDX_STATUS 16'h05F0
`define IDX_MASK 16'h05F1
`define IDX_CONTROL 16'h05F2
`define IDX_STATE 16'h05F3
`define IDX_NONE 16'hFFFF

// ----------------------------------------------------------------------
// field limits and reset values
// ----------------------------------------------------------------------
`define SELECT_MAX 4'h8
`define SELECT_RESET 4'h0
`define LEVEL_MAX 9'h12C
`define LEVEL_RESET 9'h096
`define TIME_MAX 7'h64
`define TIME_RESET 7'h01
`define CODE_UNDER_FIRST 4'h5
`define EVENT_BITS 4
`define CTRL_FAULT_RESET 0

// ----------------------------------------------------------------------
// timing: one tenth of a second and the clock period, in nanoseconds
// ----------------------------------------------------------------------
`define TENTH_SEC_NS 100000000
`define CLK_PERIOD_NS 20

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/torque_channel.v
// one torque detection channel: mode decode, persistence timer, outputs
// assumes torque, run and speed agree come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "torque_detect_map.vh"

module torque_channel #(
  parameter TENTH_CYCLES = `TENTH_SEC_NS / `CLK_PERIOD_NS
)(
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // settings
  input wire [3:0] selectCode,
  input wire [8:0] level,
  input wire [6:0] holdTime,
  // drive status
  input wire [15:0] torque,
  input wire running,
  input wire speedAgree,
  input wire faultReset,
  // results
  output reg overAlarm_q,
  output reg underAlarm_q,
  output reg fault_q
);

  reg [22:0] cyc_q;
  reg [6:0] tenths_q;
  wire enabled;
  wire isUnder;
  wire agreeOnly;
  wire shutdown;
  wire [3:0] codeLess;
  wire evalOn;
  wire cond;
  wire hit;
  wire met;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  // odd codes wait for speed agree; within each group of four the upper
  // pair shuts down
  assign codeLess = selectCode - 4'h1;
  assign enabled = (selectCode != `SELECT_RESET);
  assign isUnder = (selectCode >= `CODE_UNDER_FIRST);
  assign agreeOnly = selectCode[0];
  assign shutdown = codeLess[1];
  assign evalOn = enabled & running & (~agreeOnly | speedAgree);
  // one level serves both directions; equality counts as neither
  assign cond = isUnder ? (torque < {7'h00, level})
                        : (torque > {7'h00, level});
  assign hit = evalOn & cond;
  assign met = hit & (tenths_q >= holdTime);

  // persistence timer; any gap in the condition starts it over
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_q <= 23'h000000;
      tenths_q <= 7'h00;
    end
    else if (ce)
    begin
      if (!hit)
      begin
        cyc_q <= 23'h000000;
        tenths_q <= 7'h00;
      end
      else if (!met)
      begin
        if (cyc_q >= TENTH_CYCLES[22:0] - 23'h000001)
        begin
          cyc_q <= 23'h000000;
          tenths_q <= tenths_q + 7'h01;
        end
        else
        begin
          cyc_q <= cyc_q + 23'h000001;
        end
      end
    end
  end

  // alarms follow the condition; the fault holds until a fault reset or disable, set wins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overAlarm_q <= 1'b0;
      underAlarm_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else if (ce)
    begin
      overAlarm_q <= met & ~isUnder & ~shutdown;
      underAlarm_q <= met & isUnder & ~shutdown;
      if (met & shutdown)
        fault_q <= 1'b1;
      else if (faultReset | ~enabled)
        fault_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- logic/torque_detect.v
// dual torque detector with AXI4-Lite registers and an interrupt
// assumes a single 50 MHz clock; torque in whole percent of rated torque
`timescale 1ns/1ps
`default_nettype none
`include "torque_detect_map.vh"

module torque_detect #(
  parameter TENTH_CYCLES = `TENTH_SEC_NS / `CLK_PERIOD_NS
)(
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // axi4-lite write address
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // drive status from motor control
  input wire [15:0] torqueEstimate,
  input wire driveRunning,
  input wire speedAgree,
  // detection results
  output reg overtorqueEventOne,
  output reg undertorqueEventOne,
  output reg overtorqueEventTwo,
  output reg undertorqueEventTwo,
  output reg outputShutdown,
  output reg irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // byte address to register index; unaligned or odd addresses miss
  function [15:0] regIndex;
    input [15:0] addr;
    begin
      regIndex = `IDX_NONE;
      if (addr[1:0] == 2'h0)
        regIndex = {2'h0, addr[15:2]};
    end
  endfunction

  // true when the index names a register
  function mapped;
    input [15:0] idx;
    begin
      mapped = 1'b0;
      if (idx == `IDX_SELECT_ONE || idx == `IDX_LEVEL_ONE)
        mapped = 1'b1;
      else if (idx == `IDX_TIME_ONE || idx == `IDX_SELECT_TWO)
        mapped = 1'b1;
      else if (idx == `IDX_LEVEL_TWO || idx == `IDX_TIME_TWO)
        mapped = 1'b1;
      else if (idx == `IDX_STATUS || idx == `IDX_MASK)
        mapped = 1'b1;
      else if (idx == `IDX_CONTROL || idx == `IDX_STATE)
        mapped = 1'b1;
    end
  endfunction

  // merge the two low byte lanes of a write into a 16-bit value
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0])
        merge16[7:0] = data[7:0];
      if (strb[1])
        merge16[15:8] = data[15:8];
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [3:0] selOne_q;
  reg [8:0] levelOne_q;
  reg [6:0] timeOne_q;
  reg [3:0] selTwo_q;
  reg [8:0] levelTwo_q;
  reg [6:0] timeTwo_q;
  reg [`EVENT_BITS-1:0] status_q;
  reg [`EVENT_BITS-1:0] mask_q;
  reg faultReset_q;
  reg awHeld_q;
  reg wHeld_q;
  reg [15:0] awIdx_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  wire doWrite;
  wire [15:0] arIdx;
  wire [15:0] wMerged;
  wire [15:0] wOld;
  wire overAOne;
  wire underAOne;
  wire faultOne;
  wire overATwo;
  wire underATwo;
  wire faultTwo;
  wire [`EVENT_BITS-1:0] eventNow;
  wire [`EVENT_BITS-1:0] eventPrev;
  wire [`EVENT_BITS-1:0] eventRise;
  reg [31:0] readValue;

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  torque_channel #(
    .TENTH_CYCLES(TENTH_CYCLES)
  ) channelOne (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .selectCode(selOne_q),
    .level(levelOne_q),
    .holdTime(timeOne_q),
    .torque(torqueEstimate),
    .running(driveRunning),
    .speedAgree(speedAgree),
    .faultReset(faultReset_q),
    .overAlarm_q(overAOne),
    .underAlarm_q(underAOne),
    .fault_q(faultOne)
  );

  // second channel shares nothing with the first but its inputs
  torque_channel #(
    .TENTH_CYCLES(TENTH_CYCLES)
  ) channelTwo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .selectCode(selTwo_q),
    .level(levelTwo_q),
    .holdTime(timeTwo_q),
    .torque(torqueEstimate),
    .running(driveRunning),
    .speedAgree(speedAgree),
    .faultReset(faultReset_q),
    .overAlarm_q(overATwo),
    .underAlarm_q(underATwo),
    .fault_q(faultTwo)
  );

  // every shutdown fault is reported as overtorque, undertorque ones too
  assign eventNow = {underATwo, overATwo | faultTwo,
                     underAOne, overAOne | faultOne};
  assign eventPrev = {undertorqueEventTwo, overtorqueEventTwo,
                      undertorqueEventOne, overtorqueEventOne};
  assign eventRise = eventNow & ~eventPrev;

  // ----------------------------------------------------------------------
  // outputs and interrupt
  // ----------------------------------------------------------------------
  // outputs lag the channels one cycle so that each leaves a flip-flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overtorqueEventOne <= 1'b0;
      undertorqueEventOne <= 1'b0;
      overtorqueEventTwo <= 1'b0;
      undertorqueEventTwo <= 1'b0;
      outputShutdown <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      overtorqueEventOne <= eventNow[0];
      undertorqueEventOne <= eventNow[1];
      overtorqueEventTwo <= eventNow[2];
      undertorqueEventTwo <= eventNow[3];
      outputShutdown <= faultOne | faultTwo;
      irq <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  // address and data are parked independently, then committed together
  assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign wOld = (awIdx_q == `IDX_SELECT_ONE) ? {12'h000, selOne_q} :
                (awIdx_q == `IDX_LEVEL_ONE) ? {7'h00, levelOne_q} :
                (awIdx_q == `IDX_TIME_ONE) ? {9'h000, timeOne_q} :
                (awIdx_q == `IDX_SELECT_TWO) ? {12'h000, selTwo_q} :
                (awIdx_q == `IDX_LEVEL_TWO) ? {7'h00, levelTwo_q} :
                (awIdx_q == `IDX_TIME_TWO) ? {9'h000, timeTwo_q} :
                (awIdx_q == `IDX_MASK) ? {12'h000, mask_q} : 16'h0000;
  assign wMerged = merge16(wOld, wData_q, wStrb_q);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awIdx_q <= `IDX_NONE;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awIdx_q <= regIndex(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awIdx_q) ? `RESP_OKAY : `RESP_SLVERR;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------------
  // out-of-range values are dropped and the old setting stays
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      selOne_q <= `SELECT_RESET;
      levelOne_q <= `LEVEL_RESET;
      timeOne_q <= `TIME_RESET;
      selTwo_q <= `SELECT_RESET;
      levelTwo_q <= `LEVEL_RESET;
      timeTwo_q <= `TIME_RESET;
      mask_q <= {`EVENT_BITS{1'b0}};
      faultReset_q <= 1'b0;
    end
    else if (ce)
    begin
      faultReset_q <= 1'b0;
      if (doWrite)
      begin
        if (awIdx_q == `IDX_SELECT_ONE)
        begin
          if (wMerged <= {12'h000, `SELECT_MAX})
            selOne_q <= wMerged[3:0];
        end
        else if (awIdx_q == `IDX_LEVEL_ONE)
        begin
          if (wMerged <= {7'h00, `LEVEL_MAX})
            levelOne_q <= wMerged[8:0];
        end
        else if (awIdx_q == `IDX_TIME_ONE)
        begin
          if (wMerged <= {9'h000, `TIME_MAX})
            timeOne_q <= wMerged[6:0];
        end
        else if (awIdx_q == `IDX_SELECT_TWO)
        begin
          if (wMerged <= {12'h000, `SELECT_MAX})
            selTwo_q <= wMerged[3:0];
        end
        else if (awIdx_q == `IDX_LEVEL_TWO)
        begin
          if (wMerged <= {7'h00, `LEVEL_MAX})
            levelTwo_q <= wMerged[8:0];
        end
        else if (awIdx_q == `IDX_TIME_TWO)
        begin
          if (wMerged <= {9'h000, `TIME_MAX})
            timeTwo_q <= wMerged[6:0];
        end
        else if (awIdx_q == `IDX_MASK)
        begin
          mask_q <= wMerged[`EVENT_BITS-1:0];
        end
        else if (awIdx_q == `IDX_CONTROL)
        begin
          if (wStrb_q[0])
            faultReset_q <= wData_q[`CTRL_FAULT_RESET];
        end
      end
    end
  end

  // sticky status; a rising event beats a write-one-to-clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= {`EVENT_BITS{1'b0}};
    else if (ce)
    begin
      if (doWrite && awIdx_q == `IDX_STATUS && wStrb_q[0])
        status_q <= (status_q & ~wData_q[`EVENT_BITS-1:0]) | eventRise;
      else
        status_q <= status_q | eventRise;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  assign arIdx = regIndex(s_axi_araddr);

  // read mux; unmapped words read zero
  always @*
  begin
    readValue = 32'h00000000;
    if (arIdx == `IDX_SELECT_ONE)
      readValue = {28'h0000000, selOne_q};
    else if (arIdx == `IDX_LEVEL_ONE)
      readValue = {23'h000000, levelOne_q};
    else if (arIdx == `IDX_TIME_ONE)
      readValue = {25'h0000000, timeOne_q};
    else if (arIdx == `IDX_SELECT_TWO)
      readValue = {28'h0000000, selTwo_q};
    else if (arIdx == `IDX_LEVEL_TWO)
      readValue = {23'h000000, levelTwo_q};
    else if (arIdx == `IDX_TIME_TWO)
      readValue = {25'h0000000, timeTwo_q};
    else if (arIdx == `IDX_STATUS)
      readValue = {28'h0000000, status_q};
    else if (arIdx == `IDX_MASK)
      readValue = {28'h0000000, mask_q};
    else if (arIdx == `IDX_STATE)
      readValue = {26'h0000000, faultTwo, faultOne, eventPrev};
  end

  // one read at a time; arready drops while the answer is pending
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readValue;
        s_axi_rresp <= mapped(arIdx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- bench/torque_detect_checker.sv
// checker for the torque detector: bus handshakes and event timing
// assumes it is bound to torque_detect and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module torque_detect_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive status and results
  input wire logic driveRunning,
  input wire logic undertorqueEventOne,
  input wire logic undertorqueEventTwo,
  input wire logic outputShutdown
);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a taken address blocks the next one until the response
  a_aw_busy_low: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("awready high after take");
  // response two edges after address and data go in together
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_resp_one_beat: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid after handshake");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data not on time");
  a_read_one_beat: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  // a latched fault drops only after a finished register write; the
  // clear takes two edges from the response to reach the output
  a_fault_hold: assert property ($fell(outputShutdown)
    |-> $past(s_axi_bvalid, 2)) else $error("fault dropped without reset");
  // a stopped drive evaluates nothing, so the undertorque alarms must go quiet
  a_stopped_quiet: assert property (!driveRunning [*4]
    |-> !undertorqueEventOne && !undertorqueEventTwo)
    else $error("alarm while stopped");
  a_under_cause: assert property ($rose(undertorqueEventOne)
    |-> $past(driveRunning, 2) || $past(driveRunning, 3))
    else $error("alarm rose without running");
  // main scenarios reached
  c_fault: cover property ($rose(outputShutdown));
  c_under: cover property ($rose(undertorqueEventOne));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind torque_detect torque_detect_checker torque_detect_checker_inst (.*);
`default_nettype wire

//--- bench/motor_control_model.sv
// stand-in for the motor control: torque estimate, run and speed agree
// assumes the bench calls setDrive; values land just after an edge
`timescale 1ns/1ps
`default_nettype none
module motor_control_model (
  // clock
  input wire logic clk,
  // drive status
  output var logic [15:0] torqueEstimate,
  output var logic driveRunning,
  output var logic speedAgree
);
  // stopped with no torque until told otherwise
  initial
  begin
    torqueEstimate = 16'h0000;
    driveRunning = 1'h0;
    speedAgree = 1'h0;
  end
  // new status after an edge, as the control loop would update it
  task setDrive(input logic [15:0] t, input logic r, input logic a);
  begin
    @(posedge clk);
    torqueEstimate <= t;
    driveRunning <= r;
    speedAgree <= a;
  end
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the dual torque detector
// assumes TENTH_CYCLES of 10, so one tenth second is ten cycles
`timescale 1ns/1ps
`default_nettype none
`include "torque_detect_map.vh"
module tb_top;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, outputShutdown, driveRunning, speedAgree;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, wrResp;
  logic [31:0] s_axi_rdata, rdVal;
  logic [15:0] torqueEstimate;
  logic overtorqueEventOne, undertorqueEventOne;
  logic overtorqueEventTwo, undertorqueEventTwo;
  int nErrors = 0;
  int totalChecks = 0;
  torque_detect #(.TENTH_CYCLES(10)) torque_detect_inst (.*);
  motor_control_model motor_control_model_inst (.*);
  // 50 MHz
  always #10 clk = ~clk;
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task giveVerdict;
  begin
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    totalChecks++;
    if (g !== e)
    begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [15:0] idx, input logic [31:0] d);
    logic done;
  begin
    done = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= idx << 2;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        done = 1'h1;
        wrResp = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
  end
  endtask
  task rd(input logic [15:0] idx);
    logic done;
  begin
    done = 1'h0;
    @(posedge clk);
    s_axi_araddr <= idx << 2;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        done = 1'h1;
        rdVal = s_axi_rdata;
        rdResp = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
  end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task ev(input logic [4:0] e);
    chk("events", {27'h0, e}, {27'h0, overtorqueEventOne,
      undertorqueEventOne, overtorqueEventTwo, undertorqueEventTwo,
      outputShutdown});
  endtask
  // channel one outcome for a code once its condition is present
  function logic [4:0] expect1(input logic [3:0] c, input logic a);
    if (c == 4'h0 || (c[0] && !a))
      expect1 = 5'h00;
    else if (c <= 4'h2)
      expect1 = 5'h10;
    else if (c == 4'h5 || c == 4'h6)
      expect1 = 5'h08;
    else
      expect1 = 5'h11;
  endfunction
  // reset value of setting i: select, level, time repeat per channel
  function logic [31:0] setReset(input int i);
    setReset = i % 3 == 0 ? 32'h0 : i % 3 == 1 ? 32'h96 : 32'h1;
  endfunction
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    // reset values, then out-of-range writes that must be ignored
    for (int i = 0; i < 6; i++)
    begin
      rd(`IDX_SELECT_ONE + i);
      chk("setting", setReset(i), rdVal);
      wr(`IDX_SELECT_ONE + i,
        i % 3 == 0 ? 32'h9 : i % 3 == 1 ? 32'h12D : 32'h65);
      rd(`IDX_SELECT_ONE + i);
      chk("kept", setReset(i), rdVal);
    end
    rd(16'h0400);
    chk("unmapped", {30'h0, `RESP_SLVERR}, {30'h0, rdResp});
    chk("unmapped data", 32'h0, rdVal);
    wr(16'h0400, 32'h1);
    chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, wrResp});
    wr(`IDX_MASK, 32'hF);
    wr(`IDX_LEVEL_ONE, 32'h64);
    wr(`IDX_TIME_ONE, 32'h0);
    // every code: agree off then on, then condition gone, then reset
    for (int c = 0; c < 9; c++)
    begin
      wr(`IDX_SELECT_ONE, c);
      for (int a = 0; a < 2; a++)
      begin
        motor_control_model_inst.setDrive(c > 4 ? 16'h50 : 16'h78,
          1'h1, a[0]);
        cyc(6);
        ev(expect1(c[3:0], a[0]));
      end
      // odd codes see torque at the level, even codes a stopped drive
      motor_control_model_inst.setDrive(c[0] ? 16'h64 :
        c > 4 ? 16'h50 : 16'h78, c[0], 1'h1);
      cyc(6);
      ev(expect1(c[3:0], 1'h1) == 5'h11 ? 5'h11 : 5'h00);
      chk("irq", {31'h0, c != 0}, {31'h0, irq});
      rd(`IDX_STATUS);
      chk("status", c == 0 ? 0 : (c == 5 || c == 6) ? 2 : 1, rdVal);
      wr(`IDX_CONTROL, 32'h1);
      wr(`IDX_STATUS, 32'hF);
      cyc(2);
      ev(5'h00);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // persistence: a one-cycle drop restarts the two-tenth timer
    wr(`IDX_TIME_ONE, 32'h2);
    wr(`IDX_SELECT_ONE, 32'h2);
    motor_control_model_inst.setDrive(16'h78, 1'h1, 1'h0);
    cyc(14);
    motor_control_model_inst.setDrive(16'h64, 1'h1, 1'h0);
    motor_control_model_inst.setDrive(16'h78, 1'h1, 1'h0);
    cyc(16);
    ev(5'h00);
    cyc(10);
    ev(5'h10);
    // channel two on its own level and time, interrupt masked at first
    wr(`IDX_SELECT_ONE, 32'h0);
    wr(`IDX_MASK, 32'h0);
    wr(`IDX_LEVEL_TWO, 32'h32);
    wr(`IDX_SELECT_TWO, 32'h2);
    cyc(5);
    ev(5'h00);
    cyc(12);
    ev(5'h04);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`IDX_MASK, 32'h4);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`IDX_SELECT_TWO, 32'h8);
    motor_control_model_inst.setDrive(16'h10, 1'h1, 1'h0);
    cyc(16);
    ev(5'h05);
    rd(`IDX_STATE);
    chk("state", 32'h24, rdVal);
    motor_control_model_inst.setDrive(16'h32, 1'h1, 1'h0);
    wr(`IDX_CONTROL, 32'h1);
    wr(`IDX_STATUS, 32'hF);
    cyc(2);
    ev(5'h00);
    chk("irq", 32'h0, {31'h0, irq});
    // a low enable freezes detection; it resumes once enable returns
    ce <= 1'h0;
    motor_control_model_inst.setDrive(16'h10, 1'h1, 1'h0);
    cyc(16);
    ev(5'h00);
    ce <= 1'h1;
    cyc(16);
    ev(5'h05);
    giveVerdict;
  end
  // a hung handshake ends the run here instead of spinning forever
  initial
  begin
    #400000;
    nErrors++;
    giveVerdict;
  end
endmodule
`default_nettype wire
